// ==== verilog/mmsd_top.sv ====
// Memory map decode: program counter, fetch space, data RAM and pointers
`timescale 1ns/10ps
module mmsd_top #(
  parameter int PROG_DEPTH = mmsd_pkg::PROG_BYTES
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic [2:0] i_pc_cmd,
  input wire logic [14:0] i_pc_load,
  input wire logic [14:0] i_ret_addr,
  input wire logic i_fetch,
  input wire logic [7:0] i_flash_data,
  input wire logic i_flash_we,
  input wire logic [12:0] i_flash_waddr,
  input wire logic [7:0] i_flash_wdata,
  input wire logic i_page_erase,
  input wire logic i_dreq,
  input wire logic [2:0] i_dop,
  input wire logic [7:0] i_daddr,
  input wire logic [7:0] i_dwdata,
  input wire logic [2:0] i_dbit,
  output logic [14:0] o_pc,
  output logic [7:0] o_fetch_data,
  output logic o_fetch_valid,
  output logic [7:0] o_drdata,
  output logic o_dvalid,
  output logic o_bit_zero,
  output logic o_skip,
  output logic [15:0] o_ext_addr,
  output logic [7:0] o_stack_ptr,
  output logic [7:0] o_seg,
  output logic [7:0] o_alt_ptr,
  output logic [7:0] o_pri_ptr
);
  // Flash array width from parameter
  localparam int FAW = $clog2(PROG_DEPTH);

  typedef struct packed {
    logic [14:0] pc;
    logic [7:0] fdata;
    logic fvalid;
    logic [7:0] rdata;
    logic dvalid;
    logic bzero;
    logic skip;
    logic [15:0] ext;
    logic [7:0] sp;
    logic [7:0] seg;
    logic [7:0] alt;
    logic [7:0] pri;
  } mmsd_state_type;

  mmsd_state_type st_reg;
  mmsd_state_type st_next;

  // Program store with erase; erased bytes read zero
  logic [7:0] flash [0:PROG_DEPTH-1];
  logic [FAW-1:0] page_base;
  assign page_base = {i_flash_waddr[FAW-1:6], 6'h00};

  // Flash update: one byte write, or a whole 64-byte page erased
  always_ff @(posedge i_clk_sys) begin
    if (i_page_erase) begin
      for (int k = 0; k < mmsd_pkg::PAGE_BYTES; k++) begin
        flash[page_base + FAW'(k)] <= mmsd_pkg::ERASED_BYTE;
      end
    end else if (i_flash_we) begin
      flash[i_flash_waddr[FAW-1:0]] <= i_flash_wdata;
    end
  end

  // Decode of data address to physical RAM index
  logic [15:0] full_addr;
  logic is_stack;
  logic hit_ram;
  logic [7:0] ram_idx;
  logic is_reg;
  logic [7:0] ram_rdata;
  logic [7:0] cur;
  logic [7:0] wval;
  logic ram_we;
  logic [7:0] acc_addr;

  always_comb begin
    is_stack = (i_dop == mmsd_pkg::OP_PUSH) || (i_dop == mmsd_pkg::OP_POP);
    // Pop reads the location above the free slot
    if (i_dop == mmsd_pkg::OP_POP) begin
      acc_addr = st_reg.sp + 8'h01;
    end else if (i_dop == mmsd_pkg::OP_PUSH) begin
      acc_addr = st_reg.sp;
    end else begin
      acc_addr = i_daddr;
    end
    if (acc_addr[7] || is_stack) begin
      full_addr = {8'h00, acc_addr};
    end else begin
      full_addr = {st_reg.seg, acc_addr};
    end
    is_reg = (full_addr[15:8] == 8'h00) && full_addr[7];
    // Pointer bytes at 0FC-0FF live in registers, not RAM
    hit_ram = 1'b0;
    ram_idx = 8'h00;
    if (full_addr[15:8] == 8'h00 && !full_addr[7]) begin
      hit_ram = (full_addr[6:0] <= mmsd_pkg::LOW_RAM_TOP[6:0]);
      ram_idx = {1'b0, full_addr[6:0]};
    end else if (full_addr[15:8] == 8'h01) begin
      hit_ram = 1'b1;
      ram_idx = {1'b1, full_addr[6:0]};
    end else if (is_reg && full_addr[7:4] == mmsd_pkg::REG_BASE[7:4]) begin
      hit_ram = (full_addr[3:2] != 2'b11);
      ram_idx = {4'h7, full_addr[3:0]};
    end
    // Segment above 1 falls through: no hit, write dropped
  end

  mmsd_ram #(
    .AW(mmsd_pkg::RAM_AW)
  ) u_ram (
    .i_clk_sys(i_clk_sys),
    .i_we(ram_we),
    .i_waddr(ram_idx),
    .i_wdata(wval),
    .i_raddr(ram_idx),
    .o_rdata(ram_rdata)
  );

  // Current value of the addressed location, pointer or RAM
  always_comb begin
    if (is_reg && full_addr[7:0] == mmsd_pkg::ADDR_ALT_PTR) begin
      cur = st_reg.alt;
    end else if (is_reg && full_addr[7:0] == mmsd_pkg::ADDR_SP) begin
      cur = st_reg.sp;
    end else if (is_reg && full_addr[7:0] == mmsd_pkg::ADDR_PRI_PTR) begin
      cur = st_reg.pri;
    end else if (is_reg && full_addr[7:0] == mmsd_pkg::ADDR_SEG) begin
      cur = st_reg.seg;
    end else if (hit_ram) begin
      cur = ram_rdata;
    end else begin
      cur = 8'h00; // Unmapped locations read zero here
    end
  end

  // Value to be stored by the operation
  always_comb begin
    case (i_dop)
      mmsd_pkg::OP_WRITE: wval = i_dwdata;
      mmsd_pkg::OP_PUSH: wval = i_dwdata;
      mmsd_pkg::OP_BSET: wval = cur | (8'h01 << i_dbit);
      mmsd_pkg::OP_BCLR: wval = cur & ~(8'h01 << i_dbit);
      mmsd_pkg::OP_DSZ: wval = cur - 8'h01;
      default: wval = cur;
    endcase
  end

  // Writes reach RAM only when the decode hits real storage
  assign ram_we = i_dreq && hit_ram && (i_dop != mmsd_pkg::OP_READ)
    && (i_dop != mmsd_pkg::OP_POP);

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.fvalid = 1'b0;
    st_next.dvalid = 1'b0;
    st_next.skip = 1'b0;
    // Program counter
    case (i_pc_cmd)
      mmsd_pkg::PCC_INC: st_next.pc = st_reg.pc + 15'h0001;
      mmsd_pkg::PCC_LOAD: st_next.pc = i_pc_load;
      mmsd_pkg::PCC_IRQ: st_next.pc = mmsd_pkg::IRQ_VECTOR;
      mmsd_pkg::PCC_RET: begin
        // Empty stack pops into the trap location
        if (st_reg.sp == mmsd_pkg::SP_RESET) begin
          st_next.pc = mmsd_pkg::TRAP_ADDR;
        end else begin
          st_next.pc = i_ret_addr;
        end
      end
      default: st_next.pc = st_reg.pc;
    endcase
    // Fetch; beyond the array and at 7FFF reads the trap opcode
    if (i_fetch) begin
      st_next.fvalid = 1'b1;
      if (st_reg.pc == mmsd_pkg::TRAP_ADDR) begin
        st_next.fdata = mmsd_pkg::TRAP_OPCODE;
      end else if (32'(st_reg.pc) < PROG_DEPTH) begin
        st_next.fdata = i_flash_data;
      end else begin
        st_next.fdata = mmsd_pkg::ERASED_BYTE;
      end
    end
    // Data access
    if (i_dreq) begin
      st_next.dvalid = 1'b1;
      st_next.rdata = cur;
      st_next.bzero = ~cur[i_dbit];
      st_next.ext = full_addr;
      if (i_dop == mmsd_pkg::OP_DSZ) begin
        st_next.skip = (wval == 8'h00);
      end
      if (i_dop == mmsd_pkg::OP_PUSH) begin
        st_next.sp = st_reg.sp - 8'h01;
      end else if (i_dop == mmsd_pkg::OP_POP) begin
        st_next.sp = st_reg.sp + 8'h01;
      end else if (i_dop != mmsd_pkg::OP_READ && is_reg) begin
        case (full_addr[7:0])
          mmsd_pkg::ADDR_ALT_PTR: st_next.alt = wval;
          mmsd_pkg::ADDR_SP: st_next.sp = wval;
          mmsd_pkg::ADDR_PRI_PTR: st_next.pri = wval;
          mmsd_pkg::ADDR_SEG: st_next.seg = wval;
          default: st_next.seg = st_reg.seg;
        endcase
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      st_reg <= '0;
      st_reg.pc <= mmsd_pkg::PC_RESET;
      st_reg.sp <= mmsd_pkg::SP_RESET;
      st_reg.seg <= mmsd_pkg::SEG_RESET;
      st_reg.alt <= mmsd_pkg::PTR_RESET;
      st_reg.pri <= mmsd_pkg::PTR_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_pc = st_reg.pc;
  assign o_fetch_data = st_reg.fdata;
  assign o_fetch_valid = st_reg.fvalid;
  assign o_drdata = st_reg.rdata;
  assign o_dvalid = st_reg.dvalid;
  assign o_bit_zero = st_reg.bzero;
  assign o_skip = st_reg.skip;
  assign o_ext_addr = st_reg.ext;
  assign o_stack_ptr = st_reg.sp;
  assign o_seg = st_reg.seg;
  assign o_alt_ptr = st_reg.alt;
  assign o_pri_ptr = st_reg.pri;

  // Checks on program counter, stack, decode and the flash store
  AST_IRQ_VECTOR: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_pc_cmd == mmsd_pkg::PCC_IRQ
    |=> o_pc == 15'h00ff)
    else $error("irq vector not loaded");

  AST_PC_RESET: assert property (
    @(posedge i_clk_sys)
    i_srst
    |=> o_pc == 15'h0000)
    else $error("pc not cleared by reset");

  AST_RET_TRAP: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_pc_cmd == mmsd_pkg::PCC_RET && o_stack_ptr == 8'h6f
    |=> o_pc == 15'h7fff)
    else $error("empty return not trapped");

  AST_TRAP_FETCH: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_fetch && o_pc == 15'h7fff
    |=> o_fetch_valid && o_fetch_data == 8'h00)
    else $error("trap opcode not returned");

  AST_SP_RESET: assert property (
    @(posedge i_clk_sys)
    i_srst
    |=> o_stack_ptr == 8'h6f && o_seg == 8'h00)
    else $error("stack pointer reset wrong");

  AST_STACK_SEG0: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_PUSH
    |=> o_ext_addr[15:8] == 8'h00 && $stable(o_seg))
    else $error("stack access left segment 0");

  AST_PUSH_DEC: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_PUSH
    |=> o_stack_ptr == $past(o_stack_ptr) - 8'h01)
    else $error("push did not decrement");

  AST_POP_INC: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_POP
    |=> o_stack_ptr == $past(o_stack_ptr) + 8'h01)
    else $error("pop did not increment");

  AST_UPPER_UNEXT: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_daddr[7] && i_dop == mmsd_pkg::OP_READ
    |=> o_ext_addr == {8'h00, $past(i_daddr)})
    else $error("upper half address extended");

  AST_LOWER_EXT: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && !i_daddr[7] && i_dop == mmsd_pkg::OP_READ
    |=> o_ext_addr == {$past(o_seg), $past(i_daddr)})
    else $error("lower half not extended by segment");

  AST_SEG_WRITE: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_WRITE && i_daddr == 8'hff
    |=> o_seg == $past(i_dwdata))
    else $error("segment register write lost");

  // Holes in the map must never reach the array
  AST_LOW_GAP: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_WRITE && o_seg == 8'h00
    && i_daddr[7:4] == 4'h7 |-> !ram_we)
    else $error("write reached ram in segment 0 gap");

  AST_SEG1_RAM: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && !i_daddr[7] && o_seg == 8'h01
    |-> hit_ram)
    else $error("segment 1 access missed ram");

  AST_HIGH_SEG_DROP: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_WRITE && !i_daddr[7] && o_seg > 8'h01
    |-> !ram_we)
    else $error("write beyond segment 1 reached ram");

  AST_DSZ_SKIP: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_DSZ
    |=> o_skip == (o_drdata == 8'h01))
    else $error("decrement skip flag wrong");

  AST_BIT_TEST: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_dreq && i_dop == mmsd_pkg::OP_BSET
    |=> o_bit_zero == !o_drdata[$past(i_dbit)])
    else $error("tested bit flag wrong");

  AST_PAGE_ERASE: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_page_erase
    |=> flash[$past(page_base)] == 8'h00)
    else $error("page base byte not erased");

  AST_FLASH_WRITE: assert property (
    @(posedge i_clk_sys) disable iff (i_srst)
    i_flash_we && !i_page_erase
    |=> flash[$past(i_flash_waddr[FAW-1:0])] == $past(i_flash_wdata))
    else $error("flash byte write lost");
endmodule : mmsd_top

// ==== verilog/mmsd_pkg.sv ====
// Package: memory map constants for program and data space decode
// Functional notes
// - Program memory holds 8192 bytes, addressed by a 15-bit program counter.
// - Every interrupt loads the program counter with vector 00FF.
// - Erased program memory locations read back as 00.
// - After reset the program counter is 0, first fetch from location 0.
// - Return with stack pointer at 6F continues execution at 7FFF.
// - Fetch from 7FFF returns 00, the software trap opcode.
// - Flash is organised as erasable pages of 64 bytes.
// - Data addresses 0F0 to 0FF are sixteen RAM register bytes. Only 0F0-0FB are in RAM here; 0FC-0FF are held in registers.
// - 0FC, 0FD, 0FE, 0FF are alt pointer, stack pointer, primary pointer, segment.
// - Any bit of any data location can be set, cleared and tested.
// - Address bit 7 set: address used unextended, segment ignored.
// - Address bit 7 clear: segment register forms the upper address byte.
// - Stack accesses decode in segment 0 and leave the segment unchanged.
// - Reset loads the stack pointer with 006F.
// - Segment 0 holds 112 RAM bytes at 0000-006F, none at 0070-007F.
// - Other 128 RAM bytes sit at 0100-017F, segment 1.
// - RAM is not initialised; contents unknown until written.
// - Stack pointer decrements on push, points to next free location.
package mmsd_pkg;
  localparam int PROG_BYTES = 8192;
  localparam int PC_W = 15;
  localparam int PAGE_BYTES = 64;
  localparam logic [14:0] PC_RESET = 15'h0000;
  localparam logic [14:0] IRQ_VECTOR = 15'h00ff;
  localparam logic [14:0] TRAP_ADDR = 15'h7fff;
  localparam logic [7:0] ERASED_BYTE = 8'h00;
  localparam logic [7:0] TRAP_OPCODE = 8'h00;
  localparam logic [7:0] SP_RESET = 8'h6f;
  localparam logic [7:0] SEG_RESET = 8'h00;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] ADDR_ALT_PTR = 8'hfc;
  localparam logic [7:0] ADDR_SP = 8'hfd;
  localparam logic [7:0] ADDR_PRI_PTR = 8'hfe;
  localparam logic [7:0] ADDR_SEG = 8'hff;
  localparam logic [7:0] REG_BASE = 8'hf0;
  localparam logic [7:0] LOW_RAM_TOP = 8'h6f;
  localparam int RAM_WORDS = 256;
  localparam int RAM_AW = 8;
  // Operation codes for the data port
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_WRITE = 3'h1;
  localparam logic [2:0] OP_BSET = 3'h2;
  localparam logic [2:0] OP_BCLR = 3'h3;
  localparam logic [2:0] OP_DSZ = 3'h4;
  localparam logic [2:0] OP_PUSH = 3'h5;
  localparam logic [2:0] OP_POP = 3'h6;
  // Program counter commands
  localparam logic [2:0] PCC_HOLD = 3'h0;
  localparam logic [2:0] PCC_INC = 3'h1;
  localparam logic [2:0] PCC_LOAD = 3'h2;
  localparam logic [2:0] PCC_IRQ = 3'h3;
  localparam logic [2:0] PCC_RET = 3'h4;
endpackage : mmsd_pkg

// ==== verilog/mmsd_ram.sv ====
// Data RAM array, one read port, one write port
`timescale 1ns/10ps
module mmsd_ram #(
  parameter int AW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [7:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [7:0] o_rdata
);
  // No reset on the array: contents stay unknown until written
  logic [7:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge i_clk_sys) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Asynchronous read, registered by the caller
  assign o_rdata = mem[i_raddr];
endmodule : mmsd_ram

// ==== dv/mmsd_core_model.sv ====
// Far-side program store model feeding fetch bytes by program counter
`timescale 1ns/10ps
module mmsd_core_model (
  input wire logic i_clk_sys,
  input wire logic [14:0] i_pc,
  output logic [7:0] o_flash_data
);
  logic [7:0] mem [0:8191];
  logic [7:0] junk = 8'h5a;
  // Erased store reads 00; one known opcode at location 0
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
    mem[0] = 8'h9d;
  end
  // Beyond the 8k array nothing real answers, so show a moving pattern
  always @(posedge i_clk_sys) junk <= ~junk;
  assign o_flash_data = (i_pc < 15'h2000) ? mem[i_pc[12:0]] : junk;
endmodule : mmsd_core_model

// ==== dv/memory_map_segment_decode_bench.sv ====
// Self-checking bench for the memory map and segment decode block
`timescale 1ns/10ps
module memory_map_segment_decode_bench;
  localparam logic [2:0] RD = mmsd_pkg::OP_READ;
  localparam logic [2:0] WR = mmsd_pkg::OP_WRITE;
  logic clk = 0, srst = 1, fetch = 0, dreq = 0, fvalid, dvalid, bz, skip;
  logic [2:0] pc_cmd = 0, dop = 0, dbit = 0;
  logic [14:0] pc_load = 0, ret_addr = 0, pc;
  logic [7:0] daddr = 0, dwdata = 0, fdata, drd, sp, seg, alt, pri, flash;
  logic [15:0] ext;
  logic fwe = 0, fers = 0;
  logic [12:0] fwaddr = 0;
  logic [7:0] fwdata = 0;
  int fails = 0, compares = 0, cycles = 0;
  mmsd_core_model mmsd_core_model_inst (.i_clk_sys(clk), .i_pc(pc),
    .o_flash_data(flash));
  mmsd_top mmsd_top_inst (.i_clk_sys(clk), .i_srst(srst), .i_pc_cmd(pc_cmd),
    .i_pc_load(pc_load), .i_ret_addr(ret_addr), .i_fetch(fetch),
    .i_flash_data(flash), .i_flash_we(fwe), .i_flash_waddr(fwaddr),
    .i_flash_wdata(fwdata), .i_page_erase(fers), .i_dreq(dreq), .i_dop(dop),
    .i_daddr(daddr), .i_dwdata(dwdata), .i_dbit(dbit), .o_pc(pc),
    .o_fetch_data(fdata), .o_fetch_valid(fvalid), .o_drdata(drd),
    .o_dvalid(dvalid), .o_bit_zero(bz), .o_skip(skip), .o_ext_addr(ext),
    .o_stack_ptr(sp), .o_seg(seg), .o_alt_ptr(alt), .o_pri_ptr(pri));
  // Free-running system clock, 25 ns period
  always #12.5 clk = ~clk;
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop
  // Hang guard: tests need a few hundred cycles at most
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One data access; an idle edge first, so back-to-back calls
  // never lower and raise the strobe in the same time step
  task automatic acc(input int op, input int a, input int d, input int b);
    @(negedge clk);
    dop = 3'(op);
    daddr = 8'(a);
    dwdata = 8'(d);
    dbit = 3'(b);
    dreq = 1;
    @(negedge clk);
    dreq = 0;
    chk(16'(dvalid), 16'h0001);
  endtask : acc
  task automatic pcc(input int c, input int ld);
    @(negedge clk);
    pc_cmd = 3'(c);
    pc_load = 15'(ld);
    @(negedge clk);
    pc_cmd = mmsd_pkg::PCC_HOLD;
  endtask : pcc
  // Flash byte write or page erase, one cycle, idle edge first
  task automatic fop(input logic we, input logic er, input logic [12:0] a,
      input logic [7:0] d);
    @(negedge clk);
    fwe = we;
    fers = er;
    fwaddr = a;
    fwdata = d;
    @(negedge clk);
    fwe = 0;
    fers = 0;
  endtask : fop
  task automatic fet(input logic [7:0] exp);
    @(negedge clk);
    fetch = 1;
    @(negedge clk);
    fetch = 0;
    chk(16'(fvalid), 16'h0001);
    chk(16'(fdata), 16'(exp));
  endtask : fet
  // Main sequence; RAM is only read back where it was written first
  initial begin
    repeat (4) @(negedge clk);
    srst = 0;
    chk(16'(pc), 16'h0000);
    chk(16'(sp), 16'h006f);
    acc(WR, 8'hff, 8'h01, 0);
    chk(16'(seg), 16'h0001);
    acc(WR, 8'hfc, 8'h12, 0);
    chk(16'(alt), 16'h0012);
    acc(WR, 8'hfe, 8'h34, 0);
    chk(16'(pri), 16'h0034);
    acc(WR, 8'h10, 8'h5a, 0);
    chk(ext, 16'h0110);
    acc(WR, 8'hf5, 8'h77, 0);
    chk(ext, 16'h00f5);
    acc(WR, 8'hff, 8'h00, 0);
    acc(WR, 8'h10, 8'ha5, 0);
    acc(RD, 8'hf5, 0, 0);
    chk(16'(drd), 16'h0077);
    acc(WR, 8'h75, 8'h99, 0);
    acc(RD, 8'h75, 0, 0);
    chk(16'(drd), 16'h0000);
    acc(RD, 8'h10, 0, 0);
    chk(16'(drd), 16'h00a5);
    acc(WR, 8'hff, 8'h02, 0);
    acc(WR, 8'h10, 8'hee, 0);
    acc(RD, 8'h10, 0, 0);
    chk(16'(drd), 16'h0000);
    acc(mmsd_pkg::OP_PUSH, 0, 8'h3c, 0);
    chk(ext, 16'h006f);
    chk(16'(sp), 16'h006e);
    chk(16'(seg), 16'h0002);
    acc(mmsd_pkg::OP_POP, 0, 0, 0);
    chk(16'(drd), 16'h003c);
    chk(16'(sp), 16'h006f);
    acc(WR, 8'hff, 8'h01, 0);
    acc(RD, 8'h10, 0, 0);
    chk(16'(drd), 16'h005a);
    acc(WR, 8'hf0, 8'h00, 0);
    acc(mmsd_pkg::OP_BSET, 8'hf0, 0, 3'h3);
    chk(16'(bz), 16'h0001);
    acc(RD, 8'hf0, 0, 0);
    chk(16'(drd), 16'h0008);
    acc(mmsd_pkg::OP_BCLR, 8'hf0, 0, 3'h3);
    chk(16'(bz), 16'h0000);
    acc(RD, 8'hf0, 0, 0);
    chk(16'(drd), 16'h0000);
    acc(WR, 8'hf1, 8'h01, 0);
    acc(mmsd_pkg::OP_DSZ, 8'hf1, 0, 0);
    chk(16'(skip), 16'h0001);
    // Program counter: vector, return trap, ordinary return
    pcc(mmsd_pkg::PCC_IRQ, 0);
    chk(16'(pc), 16'h00ff);
    ret_addr = 15'h0123;
    pcc(mmsd_pkg::PCC_RET, 0);
    chk(16'(pc), 16'h7fff);
    fet(mmsd_pkg::TRAP_OPCODE);
    acc(mmsd_pkg::OP_PUSH, 0, 8'h00, 0);
    pcc(mmsd_pkg::PCC_RET, 0);
    chk(16'(pc), 16'h0123);
    pcc(mmsd_pkg::PCC_LOAD, 15'h0000);
    fet(8'h9d);
    pcc(mmsd_pkg::PCC_INC, 0);
    chk(16'(pc), 16'h0001);
    // Flash store: one byte written, then its page erased
    fop(1'b1, 1'b0, 13'h0041, 8'h55);
    fop(1'b0, 1'b1, 13'h0050, 8'h00);
    // Mid-run reset brings program counter and stack pointer back
    @(negedge clk);
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    chk(16'(pc), 16'h0000);
    chk(16'(sp), 16'h006f);
    report_and_stop();
  end
endmodule : memory_map_segment_decode_bench
